/* include/sps_pkg.sv */
// Constants shared by the positioning-stop logic and its divider
package sps_pkg;
    localparam int NUM_ENTRIES = 8;
    localparam int IDX_W = 3;
    localparam int FREQ_W = 16;
    localparam int DLY_W = 16;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hE9FC;
    localparam logic [DLY_W-1:0] DELAY_MAX = 16'hEA60;
    localparam logic [NUM_ENTRIES-1:0][FREQ_W-1:0] FREQ_DEFAULTS = {
        16'h1770, 16'h1388, 16'h0FA0, 16'h0BB8,
        16'h07D0, 16'h03E8, 16'h01F4, 16'h0000};
    localparam logic [DLY_W-1:0] DELAY_DEFAULT = 16'h0000;
    localparam logic [2:0] STOP_POSITIONING = 3'h4;
    localparam int CLK_HZ = 32'h02FA_F080;
    localparam int TICK_MS = 32'h0000_000A;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int DIV_W = 32;
    localparam logic [5:0] DIV_STEPS = 6'h20;
endpackage

/* include/sps_div_if.sv */
// Carrier between the stop sequencer and its divider
`timescale 1ns/1ps
interface sps_div_if;
    logic start;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic done;
    logic [31:0] quotient;
    modport master (output start, output dividend, output divisor,
                    input done, input quotient);
    modport slave (input start, input dividend, input divisor,
                   output done, output quotient);
endinterface

/* hdl/sps_divider.sv */
// Restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module sps_divider
    import sps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sps_div_if.slave div
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] steps;
        logic [16:0] rem;
        logic [31:0] quo;
        logic [15:0] den;
    } sps_div_state_t;

    sps_div_state_t s;
    sps_div_state_t next_s;
    logic [16:0] shifted;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        shifted = {s.rem[15:0], s.quo[31]};
        if (div.start) begin
            next_s.busy = 1'b1;
            next_s.steps = DIV_STEPS;
            next_s.rem = '0;
            next_s.quo = div.dividend;
            next_s.den = div.divisor;
        end else if (s.busy) begin
            if (shifted >= {1'b0, s.den}) begin
                next_s.rem = shifted - {1'b0, s.den};
                next_s.quo = {s.quo[30:0], 1'b1};
            end else begin
                next_s.rem = shifted;
                next_s.quo = {s.quo[30:0], 1'b0};
            end
            next_s.steps = s.steps - 6'h01;
            if (s.steps == 6'h01) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign div.done = s.done;
    assign div.quotient = s.quo;
endmodule

/* hdl/sps_stop_seq.sv */
// Positioning-stop sequencer: delay tables, interpolation and hold timer
`timescale 1ns/1ps
module sps_stop_seq
    import sps_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_stop_method_select,
    input wire logic i_freq_wr,
    input wire logic i_delay_wr,
    input wire logic [IDX_W-1:0] i_wr_index,
    input wire logic [15:0] i_wr_data,
    input wire logic [IDX_W-1:0] i_rd_index,
    input wire logic [FREQ_W-1:0] i_out_freq,
    input wire logic i_stop_cmd,
    output logic o_hold_speed,
    output logic o_decel_start,
    output logic [DLY_W-1:0] o_delay_sel,
    output logic [FREQ_W-1:0] o_freq_rd,
    output logic [DLY_W-1:0] o_delay_rd
);
    localparam int TICK_W = $clog2(TICK_LEN + 1);

    typedef enum logic [2:0] {
        SPS_IDLE = 3'h1,
        SPS_DIV = 3'h2,
        SPS_HOLD = 3'h4
    } sps_state_t;

    typedef struct packed {
        sps_state_t st;
        logic [NUM_ENTRIES-1:0][FREQ_W-1:0] freq;
        logic [NUM_ENTRIES-1:0][DLY_W-1:0] delay;
        logic [DLY_W-1:0] t2;
        logic falling;
        logic [DLY_W-1:0] delay_sel;
        logic [DLY_W-1:0] ticks;
        logic [TICK_W-1:0] tick_cnt;
        logic div_start;
        logic [31:0] div_num;
        logic [15:0] div_den;
        logic hold_speed;
        logic decel_start;
        logic [FREQ_W-1:0] freq_rd;
        logic [DLY_W-1:0] delay_rd;
    } sps_seq_state_t;

    sps_seq_state_t s;
    sps_seq_state_t next_s;
    sps_div_if div ();

    logic [NUM_ENTRIES-1:0] at_or_above;
    logic [IDX_W:0] seg_cnt;
    logic [IDX_W-1:0] lo_idx;
    logic [IDX_W-1:0] hi_idx;
    logic [FREQ_W-1:0] f1;
    logic [FREQ_W-1:0] f2;
    logic [DLY_W-1:0] t1;
    logic [DLY_W-1:0] t2;
    logic [DLY_W-1:0] t_span;
    logic [31:0] product;
    logic tick;

    // One comparator per table entry
    genvar g;
    generate
        for (g = 0; g < NUM_ENTRIES; g++) begin : g_cmp
            assign at_or_above[g] = i_out_freq >= s.freq[g];
        end
    endgenerate

    // Non-decreasing table makes the count of passed entries the segment index
    always_comb begin
        seg_cnt = '0;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            seg_cnt = seg_cnt + {{IDX_W{1'b0}}, at_or_above[i]};
        end
    end

    always_comb begin
        hi_idx = (seg_cnt == 4'h8) ? 3'h7 : seg_cnt[IDX_W-1:0];
        lo_idx = (seg_cnt == 4'h0) ? 3'h0 : 3'(seg_cnt - 4'h1);
        f1 = s.freq[lo_idx];
        f2 = s.freq[hi_idx];
        t1 = s.delay[lo_idx];
        t2 = s.delay[hi_idx];
        t_span = (t2 >= t1) ? (t2 - t1) : (t1 - t2);
        product = 32'(f2 - i_out_freq) * 32'(t_span);
    end

    assign tick = s.tick_cnt == TICK_W'(TICK_LEN - 1);

    always_comb begin
        next_s = s;
        next_s.decel_start = 1'b0;
        next_s.div_start = 1'b0;
        next_s.freq_rd = s.freq[i_rd_index];
        next_s.delay_rd = s.delay[i_rd_index];
        // Out-of-range writes saturate rather than wrap
        if (i_freq_wr) begin
            next_s.freq[i_wr_index] = (i_wr_data > FREQ_MAX) ? FREQ_MAX : i_wr_data;
        end
        if (i_delay_wr) begin
            next_s.delay[i_wr_index] = (i_wr_data > DELAY_MAX) ? DELAY_MAX : i_wr_data;
        end
        case (s.st)
            SPS_IDLE: begin
                if (i_stop_cmd) begin
                    if (i_stop_method_select == STOP_POSITIONING) begin
                        next_s.hold_speed = 1'b1;
                        next_s.t2 = t2;
                        next_s.falling = t1 > t2;
                        next_s.ticks = '0;
                        next_s.tick_cnt = '0;
                        // Equal points carry equal delays, so no division
                        if (lo_idx == hi_idx || f1 == f2 || t1 == t2) begin
                            next_s.delay_sel = t2;
                            next_s.st = SPS_HOLD;
                        end else begin
                            next_s.div_start = 1'b1;
                            next_s.div_num = product;
                            next_s.div_den = f2 - f1;
                            next_s.st = SPS_DIV;
                        end
                    end else begin
                        next_s.decel_start = 1'b1;
                    end
                end
            end
            SPS_DIV: begin
                if (div.done) begin
                    // Quotient never exceeds the span, so the low bits suffice
                    if (s.falling) begin
                        next_s.delay_sel = s.t2 + div.quotient[DLY_W-1:0];
                    end else begin
                        next_s.delay_sel = s.t2 - div.quotient[DLY_W-1:0];
                    end
                    next_s.st = SPS_HOLD;
                end
            end
            SPS_HOLD: begin
                if (s.ticks == s.delay_sel) begin
                    next_s.decel_start = 1'b1;
                    next_s.hold_speed = 1'b0;
                    next_s.st = SPS_IDLE;
                end else if (tick) begin
                    next_s.tick_cnt = '0;
                    next_s.ticks = s.ticks + 16'h0001;
                end else begin
                    next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
                end
            end
            default: begin
                next_s.st = SPS_IDLE;
                next_s.hold_speed = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s <= '0;
            s.st <= SPS_IDLE;
            s.freq <= FREQ_DEFAULTS;
            s.delay <= {NUM_ENTRIES{DELAY_DEFAULT}};
        end else begin
            s <= next_s;
        end
    end

    assign div.start = s.div_start;
    assign div.dividend = s.div_num;
    assign div.divisor = s.div_den;

    sps_divider u_div (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .div(div)
    );

    assign o_hold_speed = s.hold_speed;
    assign o_decel_start = s.decel_start;
    assign o_delay_sel = s.delay_sel;
    assign o_freq_rd = s.freq_rd;
    assign o_delay_rd = s.delay_rd;
endmodule

/* tb/sps_stop_monitor.sv */
// Checker for the positioning-stop sequencer ports
`timescale 1ns/1ps
module sps_stop_monitor
    import sps_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_stop_method_select,
    input wire logic i_stop_cmd,
    input wire logic o_hold_speed,
    input wire logic o_decel_start,
    input wire logic [DLY_W-1:0] o_delay_sel
);
    logic busy;
    int hcnt;
    // The pulse cycle is already idle, so a stop there is taken
    wire logic acc = i_stop_cmd && (!busy || o_decel_start);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            busy <= 1'b0;
            hcnt <= 0;
        end else begin
            busy <= acc ? 1'b1 : (o_decel_start ? 1'b0 : busy);
            hcnt <= o_hold_speed ? hcnt + 1 : 0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Hold rises at once; only the delay choice waits for the divider
    sequence hold_rise_s; ##1 o_hold_speed; endsequence
    sequence pulse_next_s; ##1 (o_decel_start && !o_hold_speed); endsequence
    nonpos_fast_a: assert property (
        acc && i_stop_method_select != STOP_POSITIONING |-> pulse_next_s) else $error("late decel");
    pos_hold_a: assert property (
        acc && i_stop_method_select == STOP_POSITIONING |-> hold_rise_s) else $error("no hold");
    hold_keep_a: assert property (
        o_hold_speed |=> o_hold_speed || o_decel_start) else $error("hold dropped");
    decel_pulse_a: assert property (
        o_decel_start |=> !o_decel_start) else $error("decel too long");
    hold_off_a: assert property (
        o_decel_start |-> !o_hold_speed) else $error("hold with decel");
    decel_busy_a: assert property (
        o_decel_start |-> busy) else $error("decel unasked");
    idle_quiet_a: assert property (
        !busy |-> !o_hold_speed) else $error("hold while idle");
    sel_stable_a: assert property (
        o_hold_speed && !$stable(o_delay_sel) |-> hcnt == 0 || hcnt == 34)
        else $error("delay moved");
    // Divided delays spend 34 extra cycles before the timer starts
    hold_len_a: assert property (
        o_decel_start && hcnt != 0 |-> hcnt == 32'(o_delay_sel) * TICK_LEN + 1 ||
            hcnt == 32'(o_delay_sel) * TICK_LEN + 35)
        else $error("hold length");
endmodule
bind sps_stop_seq sps_stop_monitor #(.TICK_LEN(TICK_LEN)) mon_u (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_stop_method_select(i_stop_method_select), .i_stop_cmd(i_stop_cmd),
    .o_hold_speed(o_hold_speed), .o_decel_start(o_decel_start), .o_delay_sel(o_delay_sel));

/* tb/simple_positioning_stop_test.sv */
// Self-checking bench for the positioning-stop sequencer
`timescale 1ns/1ps
module simple_positioning_stop_test;
    import sps_pkg::*;
    localparam int TL = 4;
    logic i_clk = 0, i_sys_rst = 1, i_freq_wr = 0, i_delay_wr = 0, i_stop_cmd = 0;
    logic [2:0] i_stop_method_select = 3'h0;
    logic [IDX_W-1:0] i_wr_index = '0, i_rd_index = '0;
    logic [15:0] i_wr_data = '0, i_out_freq = '0;
    logic o_hold_speed, o_decel_start;
    logic [15:0] o_delay_sel, o_freq_rd, o_delay_rd;
    int num_errors = 0, compares = 0, cyc = 0, ef[8], ed[8];
    sps_stop_seq #(.TICK_LEN(TL)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_stop_method_select(i_stop_method_select), .i_freq_wr(i_freq_wr),
        .i_delay_wr(i_delay_wr), .i_wr_index(i_wr_index), .i_wr_data(i_wr_data),
        .i_rd_index(i_rd_index), .i_out_freq(i_out_freq), .i_stop_cmd(i_stop_cmd),
        .o_hold_speed(o_hold_speed), .o_decel_start(o_decel_start), .o_delay_sel(o_delay_sel),
        .o_freq_rd(o_freq_rd), .o_delay_rd(o_delay_rd));
    initial forever #10 i_clk = ~i_clk;
    task automatic stop_test();
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Longest sequence is under 200 cycles, so this only trips on a hang
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic wr(input bit fq, input bit dl, input int idx, input int d);
        i_freq_wr = fq;
        i_delay_wr = dl;
        i_wr_index = idx[2:0];
        i_wr_data = d[15:0];
        @(posedge i_clk);
        #1;
        i_freq_wr = 0;
        i_delay_wr = 0;
        @(posedge i_clk);
        #1;
        if (fq) ef[idx] = d > 59900 ? 59900 : d;
        if (dl) ed[idx] = d > 60000 ? 60000 : d;
    endtask
    task automatic chk_tab();
        for (int i = 0; i < 8; i++) begin
            i_rd_index = i[2:0];
            repeat (2) @(posedge i_clk);
            #1;
            cmp("freq_rd", ef[i], o_freq_rd);
            cmp("delay_rd", ed[i], o_delay_rd);
        end
    endtask
    function automatic int exp_dly(input int fx, output bit dv);
        int c, h, l;
        c = 0;
        foreach (ef[i]) if (fx >= ef[i]) c++;
        h = c > 7 ? 7 : c;
        l = c > 0 ? c - 1 : 0;
        dv = !(l == h || ef[l] == ef[h] || ed[l] == ed[h]);
        if (!dv) return ed[h];
        if (ed[h] >= ed[l]) return ed[h] - (ef[h] - fx) * (ed[h] - ed[l]) / (ef[h] - ef[l]);
        return ed[h] + (ef[h] - fx) * (ed[l] - ed[h]) / (ef[h] - ef[l]);
    endfunction
    task automatic stop(input int sel, input int fx);
        int e, n;
        bit dv;
        e = exp_dly(fx, dv);
        i_stop_method_select = sel[2:0];
        i_out_freq = fx[15:0];
        i_stop_cmd = 1;
        @(posedge i_clk);
        #1;
        i_stop_cmd = 0;
        cmp("hold_at", sel == STOP_POSITIONING, o_hold_speed);
        n = 0;
        while (o_decel_start !== 1'b1 && n < 5000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        cmp("hold_end", 0, o_hold_speed);
        if (sel != STOP_POSITIONING) cmp("decel_at", 0, n);
        else begin
            cmp("delay_sel", e, o_delay_sel);
            cmp("decel_at", (dv ? 35 : 1) + e * TL, n);
        end
        @(posedge i_clk);
        #1;
        cmp("decel_len", 0, o_decel_start);
    endtask
    initial begin
        int f, d;
        void'($urandom(92086));
        ef = '{0, 500, 1000, 2000, 3000, 4000, 5000, 6000};
        ed = '{default: 0};
        repeat (2) @(posedge i_clk);
        #1 i_sys_rst = 0;
        chk_tab();
        stop(4, 9000);
        for (int i = 0; i < 8; i++) wr(1, 1, i, 59000 + $urandom % 6536);
        chk_tab();
        repeat (8) begin
            i_stop_method_select = STOP_POSITIONING;
            for (int i = 0; i < 8; i++) begin
                f = i == 0 ? $urandom % 500 : ef[i-1] + ($urandom % 4 == 0 ? 0 : $urandom % 800);
                d = (i > 0 && f == ef[i-1]) ? ed[i-1] : $urandom % 20;
                wr(1, 0, i, f);
                wr(0, 1, i, d);
            end
            stop(4, $urandom % 7000);
            stop(4, ef[$urandom % 8]);
            stop(4, $urandom % 7000);
            stop($urandom % 8, $urandom % 7000);
        end
        chk_tab();
        stop_test();
    end
endmodule
